// *** core/spcg_regs.sv ***
`timescale 1ns/100ps
module spcg_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] peripheral_clock_gate,
  input  wire logic [5:0]  short_io_offset,
  input  wire logic        external_memory_mode_bit,
  output logic      [17:0] short_io_upper_address,
  output logic      [23:0] short_io_full_address,
  output logic             debug_access_blocked,
  input  wire logic [3:0]  port_c_periph_enable,
  input  wire logic [3:0]  port_c_pins_in,
  output logic      [3:0]  port_c_pins_out,
  output logic      [3:0]  port_c_pins_oe,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  input  wire logic [3:0]  timer_b_out,
  input  wire logic [3:0]  timer_b_oe,
  input  wire logic [3:0]  second_spi_out,
  input  wire logic [3:0]  second_spi_oe,
  output logic      [3:0]  gpio_in,
  output logic      [3:0]  decoder1_timerb_in,
  output logic      [3:0]  timer_b_in,
  output logic      [3:0]  second_spi_in
);

  localparam int unsigned PIPE_N = spcg_pkg::SHORT_ADDR_DELAY - 1;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (spcg_pkg::SHORT_ADDR_DELAY < 2) begin : g_bad_delay
    $error("Short address delay must be at least two cycles");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0]                     pad_meta;
    logic [3:0]                     pad_sync;
    logic [3:0]                     alt_sel;
    logic [15:0]                    clk_gate;
    logic [1:0]                     addr_high;
    logic [15:0]                    addr_low;
    logic [PIPE_N-1:0][17:0]        pipe;
    logic [17:0]                    upper_eff;
    logic [23:0]                    full_addr;
    logic                           dbg_blocked;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
  } spcg_regs_state_t;

  spcg_regs_state_t st_reg;
  spcg_regs_state_t st_next;

  spcg_route_if rif ();

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Only the two low byte lanes carry register data
  function automatic logic [15:0] spcg_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : spcg_merge

  function automatic logic spcg_mapped(input logic [11:0] addr);
    return (addr == spcg_pkg::PORTC_ALT_FUNCTION_SELECT_ADDR) ||
           (addr == spcg_pkg::PERIPHERAL_CLOCK_GATE_ADDR) ||
           (addr == spcg_pkg::SHORT_IO_ADDR_HIGH_ADDR) ||
           (addr == spcg_pkg::SHORT_IO_ADDR_LOW_ADDR);
  endfunction : spcg_mapped

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic        setup_phase;
  logic        write_done;
  logic [15:0] merged;
  logic [15:0] rd_val;

  always_comb begin
    st_next     = st_reg;
    setup_phase = psel && !penable;
    write_done  = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    merged      = 16'h0000;
    rd_val      = 16'h0000;

    // Pads are asynchronous to clk
    st_next.pad_meta = port_c_pins_in;
    st_next.pad_sync = st_reg.pad_meta;

    // Read data is captured in setup so every output stays a flop
    unique case (paddr)
      spcg_pkg::PORTC_ALT_FUNCTION_SELECT_ADDR: begin
        rd_val = {spcg_pkg::PORTC_ALT_RESERVED_ZERO, st_reg.alt_sel};
      end
      spcg_pkg::PERIPHERAL_CLOCK_GATE_ADDR: begin
        rd_val = st_reg.clk_gate;
      end
      spcg_pkg::SHORT_IO_ADDR_HIGH_ADDR: begin
        rd_val = {spcg_pkg::SHORT_IO_ADDR_HIGH_ONES, st_reg.addr_high};
      end
      spcg_pkg::SHORT_IO_ADDR_LOW_ADDR: begin
        rd_val = st_reg.addr_low;
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase

    // one wait-free access phase per transfer
    st_next.pready  = setup_phase;
    st_next.pslverr = setup_phase && !spcg_mapped(paddr);
    st_next.prdata  = (setup_phase && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;

    if (write_done) begin
      unique case (paddr)
        spcg_pkg::PORTC_ALT_FUNCTION_SELECT_ADDR: begin
          merged = spcg_merge({12'h000, st_reg.alt_sel}, pwdata, pstrb);
          // only the four select bits store
          st_next.alt_sel = merged[3:0];
        end
        spcg_pkg::PERIPHERAL_CLOCK_GATE_ADDR: begin
          st_next.clk_gate = spcg_merge(st_reg.clk_gate, pwdata, pstrb);
        end
        spcg_pkg::SHORT_IO_ADDR_HIGH_ADDR: begin
          merged = spcg_merge({spcg_pkg::SHORT_IO_ADDR_HIGH_ONES, st_reg.addr_high},
                              pwdata, pstrb);
          st_next.addr_high = merged[1:0];
        end
        spcg_pkg::SHORT_IO_ADDR_LOW_ADDR: begin
          st_next.addr_low = spcg_merge(st_reg.addr_low, pwdata, pstrb);
        end
        default: begin
          merged = 16'h0000;
        end
      endcase
    end

    // staged so the pointer lands three edges after the write
    st_next.pipe[0] = {st_reg.addr_high, st_reg.addr_low};
    for (int i = 1; i < PIPE_N; i++) begin
      st_next.pipe[i] = st_reg.pipe[i-1];
    end
    st_next.upper_eff = st_reg.pipe[PIPE_N-1];

    // instruction gives only the low six bits
    st_next.full_addr = {st_reg.pipe[PIPE_N-1], short_io_offset};

    // debug port loses access when pointer moved while external_memory_mode_bit is set
    st_next.dbg_blocked = external_memory_mode_bit &&
                          (st_reg.pipe[PIPE_N-1] != spcg_pkg::DEBUG_SPACE_UPPER);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg           <= '0;
      st_reg.alt_sel   <= spcg_pkg::PORTC_ALT_FUNCTION_SELECT_RST;
      st_reg.clk_gate  <= spcg_pkg::PERIPHERAL_CLOCK_GATE_RST;
      st_reg.addr_high <= spcg_pkg::SHORT_IO_ADDR_HIGH_RST;
      st_reg.addr_low  <= spcg_pkg::SHORT_IO_ADDR_LOW_RST;
      for (int i = 0; i < PIPE_N; i++) begin
        st_reg.pipe[i] <= spcg_pkg::DEBUG_SPACE_UPPER;
      end
      st_reg.upper_eff <= spcg_pkg::DEBUG_SPACE_UPPER;
      st_reg.full_addr <= {spcg_pkg::DEBUG_SPACE_UPPER, 6'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Pin routing
  // ==========================================================================
  assign rif.alt_sel   = st_reg.alt_sel;
  assign rif.periph_en = port_c_periph_enable;
  assign rif.pad_in    = st_reg.pad_sync;
  assign rif.gpio_out  = gpio_out;
  assign rif.gpio_oe   = gpio_oe;
  assign rif.timer_out = timer_b_out;
  assign rif.timer_oe  = timer_b_oe;
  assign rif.spi_out   = second_spi_out;
  assign rif.spi_oe    = second_spi_oe;

  spcg_pin_route u_route (
    .clk     (clk),
    .reset_n (reset_n),
    .rif     (rif.route)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata                 = st_reg.prdata;
  assign pready                 = st_reg.pready;
  assign pslverr                = st_reg.pslverr;
  // bits 15-8 follow the package positions
  // bits 7-0 follow the package positions
  assign peripheral_clock_gate  = st_reg.clk_gate;
  assign short_io_upper_address = st_reg.upper_eff;
  assign short_io_full_address  = st_reg.full_addr;
  assign debug_access_blocked   = st_reg.dbg_blocked;
  assign port_c_pins_out        = rif.pad_out;
  assign port_c_pins_oe         = rif.pad_oe;
  assign gpio_in                = rif.gpio_in;
  assign decoder1_timerb_in     = rif.decoder_in;
  assign timer_b_in             = rif.timer_in;
  assign second_spi_in          = rif.spi_in;

endmodule : spcg_regs

// *** common/spcg_pkg.sv ***
package spcg_pkg;

  // ==========================================================================
  // Bus and register geometry
  // ==========================================================================
  localparam int unsigned APB_AW    = 12;
  localparam int unsigned APB_DW    = 32;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned PIN_COUNT = 4;

  // Register indices; the byte address is four times the index
  localparam logic [3:0] PORTC_ALT_FUNCTION_SELECT_IDX = 4'hb;
  localparam logic [3:0] PERIPHERAL_CLOCK_GATE_IDX     = 4'hc;
  localparam logic [3:0] SHORT_IO_ADDR_HIGH_IDX        = 4'hd;
  localparam logic [3:0] SHORT_IO_ADDR_LOW_IDX         = 4'he;

  localparam logic [11:0] PORTC_ALT_FUNCTION_SELECT_ADDR = {6'h00, PORTC_ALT_FUNCTION_SELECT_IDX, 2'h0};
  localparam logic [11:0] PERIPHERAL_CLOCK_GATE_ADDR     = {6'h00, PERIPHERAL_CLOCK_GATE_IDX, 2'h0};
  localparam logic [11:0] SHORT_IO_ADDR_HIGH_ADDR        = {6'h00, SHORT_IO_ADDR_HIGH_IDX, 2'h0};
  localparam logic [11:0] SHORT_IO_ADDR_LOW_ADDR         = {6'h00, SHORT_IO_ADDR_LOW_IDX, 2'h0};

  // ==========================================================================
  // Reset values and fixed read bits
  // ==========================================================================
  localparam logic [3:0]  PORTC_ALT_FUNCTION_SELECT_RST = 4'h0;
  localparam logic [15:0] PERIPHERAL_CLOCK_GATE_RST     = 16'hffff;
  localparam logic [1:0]  SHORT_IO_ADDR_HIGH_RST        = 2'h3;
  localparam logic [15:0] SHORT_IO_ADDR_LOW_RST         = 16'hffff;
  localparam logic [13:0] SHORT_IO_ADDR_HIGH_ONES       = 14'h3fff;
  localparam logic [11:0] PORTC_ALT_RESERVED_ZERO       = 12'h000;

  // ==========================================================================
  // Peripheral clock gate bit positions
  // ==========================================================================
  localparam int unsigned EXT_MEM_IF_CLK_EN_BIT     = 15;
  localparam int unsigned CONVERTER_B_CLK_EN_BIT    = 14;
  localparam int unsigned CONVERTER_A_CLK_EN_BIT    = 13;
  localparam int unsigned CAN_CLK_EN_BIT            = 12;
  localparam int unsigned DECODER_ONE_CLK_EN_BIT    = 11;
  localparam int unsigned DECODER_ZERO_CLK_EN_BIT   = 10;
  localparam int unsigned TIMER_D_CLK_EN_BIT        = 9;
  localparam int unsigned TIMER_C_CLK_EN_BIT        = 8;
  localparam int unsigned TIMER_B_CLK_EN_BIT        = 7;
  localparam int unsigned TIMER_A_CLK_EN_BIT        = 6;
  localparam int unsigned SERIAL_IF_ONE_CLK_EN_BIT  = 5;
  localparam int unsigned SERIAL_IF_ZERO_CLK_EN_BIT = 4;
  localparam int unsigned SPI_UNIT_ONE_CLK_EN_BIT   = 3;
  localparam int unsigned SPI_UNIT_ZERO_CLK_EN_BIT  = 2;
  localparam int unsigned MODULATOR_B_CLK_EN_BIT    = 1;
  localparam int unsigned MODULATOR_A_CLK_EN_BIT    = 0;

  // ==========================================================================
  // Short I/O addressing
  // ==========================================================================
  localparam int unsigned SHORT_OFFSET_W   = 6;
  localparam int unsigned UPPER_ADDR_W     = 18;
  localparam int unsigned FULL_ADDR_W      = 24;
  localparam int unsigned SHORT_ADDR_DELAY = 3;
  localparam logic [17:0] DEBUG_SPACE_UPPER = 18'h3ffff;

endpackage : spcg_pkg

// *** common/spcg_route_if.sv ***
`timescale 1ns/100ps
interface spcg_route_if;
  logic [3:0] alt_sel;
  logic [3:0] periph_en;
  logic [3:0] pad_in;
  logic [3:0] gpio_out;
  logic [3:0] gpio_oe;
  logic [3:0] timer_out;
  logic [3:0] timer_oe;
  logic [3:0] spi_out;
  logic [3:0] spi_oe;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  logic [3:0] gpio_in;
  logic [3:0] decoder_in;
  logic [3:0] timer_in;
  logic [3:0] spi_in;

  modport cfg (
    output alt_sel, periph_en, pad_in, gpio_out, gpio_oe,
    output timer_out, timer_oe, spi_out, spi_oe,
    input  pad_out, pad_oe, gpio_in, decoder_in, timer_in, spi_in
  );
  modport route (
    input  alt_sel, periph_en, pad_in, gpio_out, gpio_oe,
    input  timer_out, timer_oe, spi_out, spi_oe,
    output pad_out, pad_oe, gpio_in, decoder_in, timer_in, spi_in
  );
endinterface : spcg_route_if

// *** core/spcg_pin_route.sv ***
`timescale 1ns/100ps
module spcg_pin_route (
  input  wire logic   clk,
  input  wire logic   reset_n,
  spcg_route_if.route rif
);

  typedef struct packed {
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    logic [3:0] gpio_in;
    logic [3:0] decoder_in;
    logic [3:0] timer_in;
    logic [3:0] spi_in;
  } spcg_route_state_t;

  spcg_route_state_t route_reg;
  spcg_route_state_t route_next;

  // ==========================================================================
  // Per-pin routing
  // ==========================================================================
  always_comb begin
    route_next = '0;
    for (int i = 0; i < 4; i++) begin
      if (!rif.periph_en[i]) begin
        route_next.pad_out[i] = rif.gpio_out[i];
        route_next.pad_oe[i]  = rif.gpio_oe[i];
        route_next.gpio_in[i] = rif.pad_in[i];
      end else if (!rif.alt_sel[i]) begin
        route_next.pad_out[i]    = rif.timer_out[i];
        route_next.pad_oe[i]     = rif.timer_oe[i];
        route_next.decoder_in[i] = rif.pad_in[i];
        route_next.timer_in[i]   = rif.pad_in[i];
      end else begin
        route_next.pad_out[i] = rif.spi_out[i];
        route_next.pad_oe[i]  = rif.spi_oe[i];
        route_next.spi_in[i]  = rif.pad_in[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      route_reg <= '0;
    end else begin
      route_reg <= route_next;
    end
  end

  assign rif.pad_out    = route_reg.pad_out;
  assign rif.pad_oe     = route_reg.pad_oe;
  assign rif.gpio_in    = route_reg.gpio_in;
  assign rif.decoder_in = route_reg.decoder_in;
  assign rif.timer_in   = route_reg.timer_in;
  assign rif.spi_in     = route_reg.spi_in;

endmodule : spcg_pin_route

// *** tb/spcg_regs_sva.sv ***
`timescale 1ns/100ps
module spcg_regs_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] peripheral_clock_gate,
  input wire logic        external_memory_mode_bit,
  input wire logic [17:0] short_io_upper_address,
  input wire logic [23:0] short_io_full_address,
  input wire logic        debug_access_blocked
);
  // ==========================================================
  // Completed access
  logic acc;
  assign acc = psel && penable && pready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Properties
  AST_ALT_HIGH_ZERO :
    assert property (acc && !pwrite && paddr == 12'h02c |-> prdata[15:4] == 12'h000)
    else $error("select upper bits not zero");
  AST_HIGH_READ_ONES :
    assert property (acc && !pwrite && paddr == 12'h034 |-> prdata[15:2] == 14'h3fff)
    else $error("high pointer upper bits not ones");
  AST_LOW_LATENCY :
    assert property (acc && pwrite && paddr == 12'h038
      |-> ##4 short_io_upper_address[15:0] == $past(pwdata[15:0], 4))
    else $error("low pointer not effective on time");
  AST_HIGH_LATENCY :
    assert property (acc && pwrite && paddr == 12'h034
      |-> ##4 short_io_upper_address[17:16] == $past(pwdata[1:0], 4))
    else $error("high pointer not effective on time");
  AST_DEBUG_BLOCK :
    assert property (debug_access_blocked ==
      ($past(external_memory_mode_bit) && short_io_upper_address != 18'h3ffff))
    else $error("debug block flag wrong");
  AST_FULL_ADDR :
    assert property ($past(reset_n) |-> short_io_full_address[23:6] == short_io_upper_address)
    else $error("full address upper part wrong");
  AST_GATE_WRITE :
    assert property (acc && pwrite && paddr == 12'h030
      |=> peripheral_clock_gate[7:0] == ($past(pstrb[0]) ? $past(pwdata[7:0])
                                         : $past(peripheral_clock_gate[7:0]))
       && peripheral_clock_gate[15:8] == ($past(pstrb[1]) ? $past(pwdata[15:8])
                                          : $past(peripheral_clock_gate[15:8])))
    else $error("clock gate not written");
  AST_UNMAPPED :
    assert property (psel && !penable && paddr == 12'h03c
      |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_RESET_VALUES :
    assert property ($rose(reset_n)
      |-> peripheral_clock_gate == 16'hffff && short_io_upper_address == 18'h3ffff)
    else $error("reset values wrong");
endmodule : spcg_regs_sva

bind spcg_regs spcg_regs_sva u_sva (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr,
  .peripheral_clock_gate, .external_memory_mode_bit, .short_io_upper_address,
  .short_io_full_address, .debug_access_blocked
);

// *** tb/spcg_regs_tb.sv ***
`timescale 1ns/100ps
module spcg_regs_tb;
  // ==========================================================
  // Signals
  logic        clk, reset_n, psel, penable, pwrite, external_memory_mode_bit;
  logic        pready, pslverr, debug_access_blocked, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, wstrb, port_c_periph_enable, port_c_pins_in, gpio_out, gpio_oe;
  logic [3:0]  timer_b_out, timer_b_oe, second_spi_out, second_spi_oe;
  logic [3:0]  port_c_pins_out, port_c_pins_oe, gpio_in, decoder1_timerb_in;
  logic [3:0]  timer_b_in, second_spi_in;
  logic [5:0]  short_io_offset;
  logic [15:0] peripheral_clock_gate;
  logic [17:0] short_io_upper_address;
  logic [23:0] short_io_full_address;
  int          n_mismatch, compares;

  spcg_regs DUT (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .peripheral_clock_gate, .short_io_offset, .external_memory_mode_bit,
    .short_io_upper_address, .short_io_full_address, .debug_access_blocked,
    .port_c_periph_enable, .port_c_pins_in, .port_c_pins_out, .port_c_pins_oe, .gpio_out,
    .gpio_oe, .timer_b_out, .timer_b_oe, .second_spi_out, .second_spi_oe, .gpio_in,
    .decoder1_timerb_in, .timer_b_in, .second_spi_in
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================
  // Bus cycle; a lost answer is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    pstrb   <= wstrb;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until the edge that samples pready high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask : rdchk

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk(12'h02c, 32'h00000000);
    rdchk(12'h030, 32'h0000ffff);
    rdchk(12'h034, 32'h0000ffff);
    rdchk(12'h038, 32'h0000ffff);
    chk(short_io_upper_address, 32'h0003ffff);
  endtask : t_reset

  task automatic t_gate;
    apb(1'b1, 12'h02c, 16'hffff);
    rdchk(12'h02c, 32'h0000000f);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h030, 16'h0001 << i);
      @(negedge clk);
      chk(peripheral_clock_gate, 32'h1 << i);
    end
    apb(1'b1, 12'h030, 16'h00ff);
    rdchk(12'h030, 32'h000000ff);
    // Only the upper byte lane is written
    wstrb = 4'h2;
    apb(1'b1, 12'h030, 16'h5a5a);
    wstrb = 4'hf;
    rdchk(12'h030, 32'h00005aff);
  endtask : t_gate

  task automatic t_short;
    short_io_offset          <= 6'h2a;
    external_memory_mode_bit <= 1'b1;
    apb(1'b1, 12'h038, 16'h1234);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(short_io_upper_address, 32'h0003ffff);
    @(negedge clk);
    chk(short_io_upper_address, 32'h00031234);
    chk(short_io_full_address, 32'h00c48d2a);
    chk(debug_access_blocked, 32'h1);
    apb(1'b1, 12'h034, 16'h0000);
    rdchk(12'h034, 32'h0000fffc);
    rdchk(12'h038, 32'h00001234);
    chk(short_io_upper_address, 32'h00001234);
    external_memory_mode_bit <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(debug_access_blocked, 32'h0);
    // handler puts the saved pointer back
    apb(1'b1, 12'h034, 16'hffff);
    apb(1'b1, 12'h038, 16'hffff);
    rdchk(12'h034, 32'h0000ffff);
    rdchk(12'h038, 32'h0000ffff);
    external_memory_mode_bit <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(debug_access_blocked, 32'h0);
    apb(1'b1, 12'h03c, 16'hffff);
    chk(err, 32'h1);
    rdchk(12'h03c, 32'h0);
  endtask : t_short

  // Expected routing is rebuilt per pin from enable and select
  task automatic pin_case(input logic [3:0] alt, input logic [3:0] en);
    logic [3:0] sp, tm;
    apb(1'b1, 12'h02c, {12'h000, alt});
    port_c_periph_enable <= en;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sp = en & alt;
    tm = en & ~alt;
    chk(port_c_pins_oe, (~en & gpio_oe) | (sp & second_spi_oe) | (tm & timer_b_oe));
    chk(port_c_pins_out, (~en & gpio_out) | (sp & second_spi_out) | (tm & timer_b_out));
    chk(gpio_in, ~en & port_c_pins_in);
    chk(second_spi_in, sp & port_c_pins_in);
    chk({decoder1_timerb_in, timer_b_in}, {2{tm & port_c_pins_in}});
  endtask : pin_case

  task automatic t_pins;
    pin_case(4'h5, 4'hf);
    pin_case(4'ha, 4'hf);
    @(posedge clk);
    {port_c_pins_in, gpio_out, gpio_oe, timer_b_out, timer_b_oe, second_spi_out,
      second_spi_oe} <= 28'h6ac5396;
    pin_case(4'h3, 4'h6);
    pin_case(4'hc, 4'h0);
  endtask : t_pins

  task final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {short_io_offset, external_memory_mode_bit, port_c_periph_enable} = '0;
    {port_c_pins_in, gpio_out, gpio_oe, timer_b_out, timer_b_oe, second_spi_out,
      second_spi_oe} = 28'h953ac69;
    n_mismatch = 0;
    compares = 0;
    wstrb = 4'hf;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_gate();
    t_short();
    t_pins();
    // Reset lands while a pointer write is still in the pipeline
    apb(1'b1, 12'h038, 16'h0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    final_report();
  end
endmodule : spcg_regs_tb
